// File: design/dmapg_top.sv
// dma page address generator top: i/o decode, page access, address out
// assumes i/o strobes and dma controls are synchronous one-cycle samples
`timescale 1ns/1ps
`default_nettype none
module dmapg_top
  import dmapg_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // processor i/o cycle
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  // i/o answer and unit selects
  output logic [7:0] IO_RDATA,
  output logic IO_RVALID,
  output logic SEL_PAGE,
  output logic SEL_PRIMARY_DMA_UNIT,
  output logic SEL_SECONDARY_DMA_UNIT,
  // dma controls and controller addresses
  input wire logic DMA_ACTIVE,
  input wire logic [2:0] DMA_CH,
  input wire logic REFRESH,
  input wire logic [15:0] PRIMARY_DMA_UNIT_ADDR,
  input wire logic [15:0] SECONDARY_DMA_UNIT_ADDR,
  // system address
  output logic [23:0] SYS_ADDR,
  output logic UPPER_BYTE_SELECT,
  output logic ADDR_VALID,
  output logic CASCADE_CYCLE
);

  dmapg_pg_if pg ();

  logic io_cyc;
  logic [3:0] hit_slot;
  logic reg_hit;
  dmapg_xfer_t nxt_kind;
  logic [2:0] nxt_xslot;
  logic [23:0] nxt_addr;
  logic nxt_ube;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic sel_page_ff;
  logic sel_pri_ff;
  logic sel_sec_ff;
  logic [23:0] addr_ff;
  logic ube_ff;
  logic avalid_ff;
  logic cascade_ff;

  // i/o address decode
  assign io_cyc = IO_WR || IO_RD;
  assign hit_slot = dmapg_slot_of(IO_ADDR);
  assign reg_hit = hit_slot[3];

  // page file hookup
  assign pg.wr_en = IO_WR && reg_hit;
  assign pg.wr_slot = hit_slot[2:0];
  assign pg.wr_data = IO_WDATA;
  assign pg.rd_slot = hit_slot[2:0];
  assign pg.xf_slot = nxt_xslot;

  dmapg_regs u_regs (
    .clk(MCLK),
    .rst_n(RST_N),
    .pg(pg.regs)
  );

  // cycle kind: refresh wins over a channel transfer
  always_comb begin
    nxt_kind = XF_NONE;
    nxt_xslot = DMA_CH;
    if (REFRESH) begin
      nxt_kind = XF_REF;
      nxt_xslot = REF_SLOT;
    end else if (DMA_ACTIVE) begin
      if (DMA_CH < CASCADE_CH) begin
        nxt_kind = XF_BYTE; // primary unit channels
      end else if (DMA_CH != CASCADE_CH) begin
        nxt_kind = XF_WORD; // secondary unit channels
      end
    end
  end

  dmapg_amux u_amux (
    .kind(nxt_kind),
    .page(pg.xf_page),
    .pri_addr(PRIMARY_DMA_UNIT_ADDR),
    .sec_addr(SECONDARY_DMA_UNIT_ADDR),
    .addr(nxt_addr),
    .ube(nxt_ube)
  );

  // read answer, one cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_ff <= RDATA_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= IO_RD && reg_hit;
      if (IO_RD && reg_hit) begin
        rdata_ff <= pg.rd_data;
      end else begin
        rdata_ff <= RDATA_RST;
      end
    end
  end

  // unit chip selects for the current i/o cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sel_page_ff <= 1'b0;
      sel_pri_ff <= 1'b0;
      sel_sec_ff <= 1'b0;
    end else begin
      sel_page_ff <= io_cyc && dmapg_in(IO_ADDR, IO_PAGE_LO, IO_PAGE_HI);
      sel_pri_ff <= io_cyc && dmapg_in(IO_ADDR, IO_PRI_LO, IO_PRI_HI);
      sel_sec_ff <= io_cyc && dmapg_in(IO_ADDR, IO_SEC_LO, IO_SEC_HI);
    end
  end

  // registered system address
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      addr_ff <= ADDR_RST;
      ube_ff <= 1'b0;
      avalid_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      ube_ff <= nxt_ube;
      avalid_ff <= (nxt_kind != XF_NONE);
    end
  end

  // channel 4 only passes primary unit requests on; no address formed
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cascade_ff <= 1'b0;
    end else begin
      cascade_ff <= DMA_ACTIVE && !REFRESH && (DMA_CH == CASCADE_CH);
    end
  end

  // outputs straight from flops
  assign IO_RDATA = rdata_ff;
  assign IO_RVALID = rvalid_ff;
  assign SEL_PAGE = sel_page_ff;
  assign SEL_PRIMARY_DMA_UNIT = sel_pri_ff;
  assign SEL_SECONDARY_DMA_UNIT = sel_sec_ff;
  assign SYS_ADDR = addr_ff;
  assign UPPER_BYTE_SELECT = ube_ff;
  assign ADDR_VALID = avalid_ff;
  assign CASCADE_CYCLE = cascade_ff;

  // channel 1 serves the serial link, 2 the diskette, 4 cascades; the rest are spare.
  // channels 0-3 are handled alike here, as are 5-7; channel 4 only cascades

  // checks
  sequence s_byte_req;
    DMA_ACTIVE && !REFRESH && (DMA_CH < 3'h4);
  endsequence

  sequence s_word_req;
    DMA_ACTIVE && !REFRESH && (DMA_CH > 3'h4);
  endsequence

  sequence s_page_wr(logic [9:0] ofs);
    IO_WR && (IO_ADDR == ofs);
  endsequence

  a_byte_low_addr: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_byte_req |=> (SYS_ADDR[15:0] == $past(PRIMARY_DMA_UNIT_ADDR)) && ADDR_VALID)
    else $error("byte cycle low address not from primary unit");

  a_byte_ube: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_byte_req |=> (UPPER_BYTE_SELECT == !SYS_ADDR[0]))
    else $error("byte cycle upper select not inverse of a0");

  a_word_shift: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_word_req |=> (SYS_ADDR[16:1] == $past(SECONDARY_DMA_UNIT_ADDR)))
    else $error("word cycle address not shifted secondary address");

  a_word_even: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_word_req |=> !SYS_ADDR[0] && !UPPER_BYTE_SELECT)
    else $error("word cycle a0 or upper select not low");

  a_ch0_page: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_page_wr(PG_CH0_OFS) ##1 (!IO_WR && DMA_ACTIVE && !REFRESH && DMA_CH == 3'h0)
    |=> SYS_ADDR[23:16] == $past(IO_WDATA, 2))
    else $error("channel 0 page not used as high address");

  a_ch5_page: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_page_wr(PG_CH5_OFS) ##1 (!IO_WR && DMA_ACTIVE && !REFRESH && DMA_CH == 3'h5)
    |=> SYS_ADDR[23:17] == $past(IO_WDATA[7:1], 2))
    else $error("channel 5 page not used as high address");

  a_page_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !pg.wr_en |=> $stable(pg.all_pages))
    else $error("page register changed without an i/o write");

  a_cascade_none: assert property (@(posedge MCLK) disable iff (!RST_N)
    (DMA_ACTIVE && !REFRESH && DMA_CH == 3'h4) |=> CASCADE_CYCLE && !ADDR_VALID)
    else $error("channel 4 formed an address");

  a_read_back: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_page_wr(PG_CH7_OFS) ##1 (IO_RD && !IO_WR && IO_ADDR == PG_CH7_OFS)
    |=> IO_RVALID && (IO_RDATA == $past(IO_WDATA, 2)))
    else $error("page read did not return written byte");

  a_sec_decode: assert property (@(posedge MCLK) disable iff (!RST_N)
    (io_cyc && IO_ADDR[9:5] == 5'h06) |=> SEL_SECONDARY_DMA_UNIT && !SEL_PAGE)
    else $error("secondary unit window not decoded");

  a_ref_page: assert property (@(posedge MCLK) disable iff (!RST_N)
    (REFRESH && !IO_WR) |=> SYS_ADDR[23:16] == pg.all_pages[39:32])
    else $error("refresh cycle did not use refresh page");

endmodule : dmapg_top
`default_nettype wire

// File: design/dmapg_pkg.sv
// dma page address generator: shared constants, types and decode helpers
// assumes a 10-bit i/o address space and 8-bit page registers
package dmapg_pkg;

  // i/o offsets of the page registers
  localparam logic [9:0] PG_CH0_OFS = 10'h087;
  localparam logic [9:0] PG_CH1_OFS = 10'h083;
  localparam logic [9:0] PG_CH2_OFS = 10'h081;
  localparam logic [9:0] PG_CH3_OFS = 10'h082;
  localparam logic [9:0] PG_CH5_OFS = 10'h08B;
  localparam logic [9:0] PG_CH6_OFS = 10'h089;
  localparam logic [9:0] PG_CH7_OFS = 10'h08A;
  localparam logic [9:0] PG_REF_OFS = 10'h08F;

  // i/o decode windows
  localparam logic [9:0] IO_PAGE_LO = 10'h080;
  localparam logic [9:0] IO_PAGE_HI = 10'h09F;
  localparam logic [9:0] IO_PRI_LO = 10'h000;
  localparam logic [9:0] IO_PRI_HI = 10'h01F;
  localparam logic [9:0] IO_SEC_LO = 10'h0C0;
  localparam logic [9:0] IO_SEC_HI = 10'h0DF;

  // reset values and fixed slots
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [2:0] REF_SLOT = 3'h4; // slot 4 holds refresh
  localparam logic [2:0] CASCADE_CH = 3'h4;
  localparam logic [23:0] ADDR_RST = 24'h000000;

  // kind of bus cycle the address is formed for
  typedef enum logic [1:0] {
    XF_NONE,
    XF_BYTE,
    XF_WORD,
    XF_REF
  } dmapg_xfer_t;

  // map an i/o address to {hit, slot}; slot equals channel, refresh in 4
  function automatic logic [3:0] dmapg_slot_of(input logic [9:0] a);
    case (a)
      PG_CH0_OFS: dmapg_slot_of = 4'h8;
      PG_CH1_OFS: dmapg_slot_of = 4'h9;
      PG_CH2_OFS: dmapg_slot_of = 4'hA;
      PG_CH3_OFS: dmapg_slot_of = 4'hB;
      PG_REF_OFS: dmapg_slot_of = 4'hC;
      PG_CH5_OFS: dmapg_slot_of = 4'hD;
      PG_CH6_OFS: dmapg_slot_of = 4'hE;
      PG_CH7_OFS: dmapg_slot_of = 4'hF;
      default: dmapg_slot_of = 4'h0;
    endcase
  endfunction : dmapg_slot_of

  // inclusive window compare
  function automatic logic dmapg_in(input logic [9:0] a,
                                    input logic [9:0] lo,
                                    input logic [9:0] hi);
    dmapg_in = (a >= lo) && (a <= hi);
  endfunction : dmapg_in

endpackage : dmapg_pkg

// File: design/dmapg_pg_if.sv
// page register file access: i/o write port, read port, transfer lookup
// assumes one clock; the top module drives the write, read and transfer slots, the register file the answers
`timescale 1ns/1ps
`default_nettype none
interface dmapg_pg_if;
  logic wr_en;
  logic [2:0] wr_slot;
  logic [7:0] wr_data;
  logic [2:0] rd_slot;
  logic [7:0] rd_data;
  logic [2:0] xf_slot;
  logic [7:0] xf_page;
  logic [63:0] all_pages;

  modport regs (input wr_en, wr_slot, wr_data, rd_slot, xf_slot,
                output rd_data, xf_page, all_pages);
  modport user (output wr_en, wr_slot, wr_data, rd_slot, xf_slot,
                input rd_data, xf_page, all_pages);
endinterface : dmapg_pg_if
`default_nettype wire

// File: design/dmapg_regs.sv
// eight 8-bit page registers: seven channels plus refresh
// assumes writes come from decoded i/o cycles in the top module
`timescale 1ns/1ps
`default_nettype none
module dmapg_regs
  import dmapg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access port
  dmapg_pg_if.regs pg
);

  logic [7:0] page_ff [8];

  // pages only change on an i/o write, never by a transfer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        page_ff[i] <= PAGE_RST;
      end
    end else if (pg.wr_en) begin
      page_ff[pg.wr_slot] <= pg.wr_data;
    end
  end

  // read and transfer lookups
  assign pg.rd_data = page_ff[pg.rd_slot];
  assign pg.xf_page = page_ff[pg.xf_slot];

  // flat view for hold checks
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pg.all_pages[i*8 +: 8] = page_ff[i];
    end
  end

endmodule : dmapg_regs
`default_nettype wire

// File: design/dmapg_amux.sv
// system address former: page joined with controller address
// assumes kind, page and addresses are stable inputs for one cycle
`timescale 1ns/1ps
`default_nettype none
module dmapg_amux
  import dmapg_pkg::*;
(
  // cycle kind and sources
  input wire dmapg_xfer_t kind,
  input wire logic [7:0] page,
  input wire logic [15:0] pri_addr,
  input wire logic [15:0] sec_addr,
  // formed address
  output logic [23:0] addr,
  output logic ube
);

  // byte cycles take a0 from the primary unit, word cycles shift left one
  always_comb begin
    case (kind)
      XF_BYTE, XF_REF: begin
        addr = {page, pri_addr};
        ube = ~pri_addr[0];
      end
      XF_WORD: begin
        addr = {page[7:1], sec_addr, 1'b0};
        ube = 1'b0;
      end
      default: begin
        addr = ADDR_RST;
        ube = 1'b0;
      end
    endcase
  end

endmodule : dmapg_amux
`default_nettype wire

// File: verif/dmapg_ctl_model.sv
// controller-side model: drives channel number, cycle kind and unit addresses
// assumes the bench changes run and its qualifiers on a falling edge by nba
`timescale 1ns/1ps
`default_nettype none
module dmapg_ctl_model (
  // bench control
  input wire logic clk,
  input wire logic run,
  input wire logic [2:0] ch,
  input wire logic ref_req,
  input wire logic [15:0] start,
  // controller outputs
  output logic active,
  output logic [2:0] ch_o,
  output logic refresh,
  output logic [15:0] pri_addr,
  output logic [15:0] sec_addr
);
  logic busy;
  logic word;
  // word channels sit in the secondary unit, the rest in the primary
  assign word = !ref_req && (ch > 3'h4);
  // quiet start so every input has a value at time zero
  initial begin
    busy = 1'b0;
    active = 1'b0;
    ch_o = 3'h0;
    refresh = 1'b0;
    pri_addr = 16'h0000;
    sec_addr = 16'h0000;
  end
  // an idle unit shows the inverse of its last value, never a held address
  always @(negedge clk) begin
    active <= run;
    refresh <= run && ref_req;
    busy <= run;
    if (run && !busy) ch_o <= ch;
    // exactly one update of each address per edge
    if (run && !word) begin
      pri_addr <= busy ? pri_addr + 16'h0001 : start; // wraps in 16 bits
    end else begin
      pri_addr <= ~pri_addr;
    end
    if (run && word) begin
      sec_addr <= busy ? sec_addr + 16'h0001 : start;
    end else begin
      sec_addr <= ~sec_addr;
    end
  end
endmodule : dmapg_ctl_model
`default_nettype wire

// File: verif/dmapg_page_address_gen_tb_top.sv
// self-checking bench for the page address generator top
// assumes the controller model drives the dma inputs, the bench the i/o cycle
`timescale 1ns/1ps
`default_nettype none
module dmapg_page_address_gen_tb_top;
  import dmapg_pkg::*;
  typedef struct packed {
    logic wr; logic rd; logic [9:0] a; logic [7:0] d; logic rv; logic [7:0] q; logic [2:0] s;
  } dmapg_row_t;
  logic clk, rst_n, io_wr, io_rd, run, m_ref;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic [2:0] m_ch, chn;
  logic [15:0] m_start, pa, sa;
  logic [23:0] sys_addr;
  logic io_rvalid, sel_pg, sel_pri, sel_sec, act, rf, ube, addr_valid, casc;
  logic [7:0] pg [8] = '{8'h5A, 8'hC3, 8'h81, 8'h3C, 8'h7E, 8'h13, 8'hA6, 8'hFF};
  int failures = 0;
  int cmp_count = 0;
  // io rows: strobes, address, data, then rvalid, read data, {page,pri,sec}
  dmapg_row_t rows [28] = '{
    '{1,0,10'h087,8'h5A,0,8'h00,3'b100}, '{1,0,10'h083,8'hC3,0,8'h00,3'b100},
    '{1,0,10'h081,8'h81,0,8'h00,3'b100}, '{1,0,10'h082,8'h3C,0,8'h00,3'b100},
    '{1,0,10'h08F,8'h7E,0,8'h00,3'b100}, '{1,0,10'h08B,8'h13,0,8'h00,3'b100},
    '{1,0,10'h089,8'hA6,0,8'h00,3'b100}, '{1,0,10'h08A,8'hFF,0,8'h00,3'b100},
    '{1,0,10'h080,8'hEE,0,8'h00,3'b100}, '{1,0,10'h09F,8'hEE,0,8'h00,3'b100},
    '{0,1,10'h087,8'h00,1,8'h5A,3'b100}, '{0,1,10'h083,8'h00,1,8'hC3,3'b100},
    '{0,1,10'h081,8'h00,1,8'h81,3'b100}, '{0,1,10'h082,8'h00,1,8'h3C,3'b100},
    '{0,1,10'h08F,8'h00,1,8'h7E,3'b100}, '{0,1,10'h08B,8'h00,1,8'h13,3'b100},
    '{0,1,10'h089,8'h00,1,8'hA6,3'b100}, '{0,1,10'h08A,8'h00,1,8'hFF,3'b100},
    '{0,1,10'h080,8'h00,0,8'h00,3'b100}, '{0,1,10'h09F,8'h00,0,8'h00,3'b100},
    '{0,1,10'h000,8'h00,0,8'h00,3'b010}, '{0,1,10'h01F,8'h00,0,8'h00,3'b010},
    '{0,1,10'h0C0,8'h00,0,8'h00,3'b001}, '{0,1,10'h0DF,8'h00,0,8'h00,3'b001},
    '{1,0,10'h020,8'h00,0,8'h00,3'b000}, '{0,1,10'h07F,8'h00,0,8'h00,3'b000},
    '{0,1,10'h0A0,8'h00,0,8'h00,3'b000}, '{0,1,10'h0E0,8'h00,0,8'h00,3'b000}};

  // clock at 10 MHz
  initial clk = 1'b0;
  always #50 clk = ~clk;

  dmapg_top dut (.MCLK(clk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid), .SEL_PAGE(sel_pg),
    .SEL_PRIMARY_DMA_UNIT(sel_pri), .SEL_SECONDARY_DMA_UNIT(sel_sec), .DMA_ACTIVE(act),
    .DMA_CH(chn), .REFRESH(rf), .PRIMARY_DMA_UNIT_ADDR(pa), .SECONDARY_DMA_UNIT_ADDR(sa),
    .SYS_ADDR(sys_addr), .UPPER_BYTE_SELECT(ube), .ADDR_VALID(addr_valid),
    .CASCADE_CYCLE(casc));
  dmapg_ctl_model ctl (.clk(clk), .run(run), .ch(m_ch), .ref_req(m_ref), .start(m_start),
    .active(act), .ch_o(chn), .refresh(rf), .pri_addr(pa), .sec_addr(sa));

  // verdict and end of run
  task automatic results();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // i/o answer compare: {rvalid, read data, selects}
  task automatic chk_io(input logic [11:0] e);
    cmp_count++;
    if ({io_rvalid, io_rdata, sel_pg, sel_pri, sel_sec} !== e) begin
      failures++;
      $display("[FAIL] %0t io answer %h expected %h", $time, {io_rvalid, io_rdata}, e);
    end
  endtask : chk_io

  // address compare: {valid, cascade, upper select, address}
  task automatic chk_addr(input logic [26:0] e);
    cmp_count++;
    if ({addr_valid, casc, ube, sys_addr} !== e) begin
      failures++;
      $display("[FAIL] %0t address %h expected %h", $time, sys_addr, e);
    end
  endtask : chk_addr

  // expected address from what the controllers drive now
  function automatic logic [26:0] exp_addr();
    logic [26:0] e;
    e = 27'h0;
    if (rf) e = {2'b10, ~pa[0], pg[4], pa};
    else if (act && chn == 3'h4) e = {3'b010, 24'h0};
    else if (act && chn < 3'h4) e = {2'b10, ~pa[0], pg[chn], pa};
    else if (act) e = {3'b100, pg[chn][7:1], sa, 1'b0};
    return e;
  endfunction : exp_addr

  // one i/o cycle, answer checked in the following cycle
  task automatic io_chk(input dmapg_row_t r);
    @(negedge clk);
    io_wr <= r.wr;
    io_rd <= r.rd;
    io_addr <= r.a;
    io_wdata <= r.d;
    @(negedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1 chk_io({r.rv, r.q, r.s});
  endtask : io_chk

  // one address cycle: predict from the inputs, compare after the edge
  task automatic step();
    logic [26:0] e;
    @(negedge clk);
    #1 e = exp_addr();
    @(posedge clk);
    #1 chk_addr(e);
  endtask : step

  // a transfer of n+1 cycles, the first n of them checked, then one idle cycle
  task automatic xfer(input logic [2:0] c, input logic r, input logic [15:0] s, input int n);
    @(negedge clk);
    run <= 1'b1;
    m_ch <= c;
    m_ref <= r;
    m_start <= s;
    repeat (n) step();
    @(negedge clk);
    run <= 1'b0;
    step();
  endtask : xfer

  // watchdog well past the expected run of about 160 cycles
  initial begin
    #500000;
    failures++;
    results();
  end

  // main sequence
  initial begin
    {rst_n, io_wr, io_rd, run, m_ref} = 5'h0;
    {io_addr, io_wdata, m_ch, m_start} = 37'h0;
    repeat (16) @(negedge clk);
    chk_addr(27'h0);
    chk_io(12'h000);
    rst_n <= 1'b1;
    foreach (rows[i]) io_chk(rows[i]);
    // write and read together: the read shows the old value
    io_chk('{1,1,10'h083,8'h11,1,8'hC3,3'b100});
    io_chk('{0,1,10'h083,8'h00,1,8'h11,3'b100});
    pg[1] = 8'h11;
    // every channel across a page wrap, then refresh over an active cycle
    for (int c = 0; c < 8; c++) xfer(c[2:0], 1'b0, 16'hFFFE, 4);
    xfer(3'h2, 1'b1, 16'hFFFF, 3);
    io_chk('{0,1,10'h087,8'h00,1,8'h5A,3'b100});
    io_chk('{0,1,10'h08B,8'h00,1,8'h13,3'b100});
    // a page write followed at once by a transfer on that channel
    @(negedge clk);
    io_wr <= 1'b1;
    io_addr <= 10'h087;
    io_wdata <= 8'h66;
    run <= 1'b1;
    m_ch <= 3'h0;
    m_ref <= 1'b0;
    m_start <= 16'h1234;
    @(negedge clk);
    io_wr <= 1'b0;
    pg[0] = 8'h66;
    #1 begin
      logic [26:0] e0;
      e0 = exp_addr();
      @(posedge clk);
      #1 chk_addr(e0);
    end
    @(negedge clk);
    run <= 1'b0;
    step();
    // a page write followed at once by a read of that page
    @(negedge clk);
    io_wr <= 1'b1;
    io_addr <= 10'h08A;
    io_wdata <= 8'h5C;
    @(negedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    pg[7] = 8'h5C;
    @(negedge clk);
    io_rd <= 1'b0;
    #1 chk_io({1'b1, 8'h5C, 3'b100});
    // reset in mid-transfer clears outputs and pages
    @(negedge clk);
    run <= 1'b1;
    m_ch <= 3'h7;
    m_start <= 16'h0100;
    repeat (3) @(negedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk_addr(27'h0);
    chk_io(12'h000);
    @(negedge clk);
    rst_n <= 1'b1;
    run <= 1'b0;
    pg = '{default: 8'h00};
    io_chk('{0,1,10'h08A,8'h00,1,8'h00,3'b100});
    xfer(3'h7, 1'b0, 16'h8001, 2);
    results();
  end
endmodule : dmapg_page_address_gen_tb_top
`default_nettype wire
